// ### hw/reset_power_watchdog_ctrl.sv
// Reset source merger, power-mode control and watchdog host for the core
`default_nettype none

// Behaviour
// - stop bit stops core and oscillator, reads zero
// - idle bit gates core clock only, reads zero
// - reset halts core, presets registers, ports, timers
// - memory kept, stack pointer reset by reset
// - port latches all ones during reset
// - supply resets drive pin low for 100 ms
// - exit clears PC, default clock, watchdog on
// - power-on sets only power-on cause flag
// - supply low holds reset, exits like power-on
// - pin low resets, 12 cycles, pin flag
// - enabled clock loss over 100 us resets
// - enabled comparator below resets, pin untouched
// - enabled convert input low resets, blocks conversions
// - 21-bit watchdog overflow resets, pin untouched
// - key A5 enables and restarts watchdog
// - reset enables watchdog; lock ignores disables
// - disable needs DE then AD within 4
// - key FF locks out disable only
// - interval four power three plus field
module reset_power_watchdog_ctrl
  import rst_pwr_pkg::*;
#(
  parameter int unsigned SUPPLY_CYC     = SUPPLY_SETTLE_CYC,
  parameter int unsigned CLOCK_LOSS_CYC_P = CLOCK_LOSS_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire sfr_req_s   sfr_req,
  output logic [7:0]      sfr_rdata,
  input  wire logic       supply_ok,
  input  wire logic       supply_monitor_enable_pin,
  input  wire logic       rst_pin_in,
  output logic            rst_pin_out,
  output logic            rst_pin_oe_n,
  input  wire logic       sysclk_tick,
  input  wire logic       osc_stable,
  input  wire logic       irq_pending,
  input  wire logic       noninverting_above_inverting,
  input  wire logic       convert_start_input,
  output logic            sys_reset,
  output logic            port_preset,
  output logic            osc_enable,
  output logic            osc_default_sel,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            adc_convert_start
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_RUN, ST_HOLD, ST_SETTLE, ST_PIN_EXIT, ST_CLK_WAIT
  } state_e;

  state_e           state_r;
  state_e           state_nxt;
  cause_e           cause_r;
  cause_e           cause_nxt;
  cause_e           trig;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] loss_cnt_r;
  logic [7:0]       flags_r;
  logic [7:0]       rdata_r;
  logic             clk_loss_en_r;
  logic             cmp_en_r;
  logic             cnv_en_r;
  logic             sw_force_r;
  logic             por_force_r;
  logic             idle_r;
  logic             stop_r;
  logic             cnv_prev_r;
  logic             sys_reset_r;
  logic             port_preset_r;
  logic             pin_oe_n_r;
  logic             osc_en_r;
  logic             osc_def_r;
  logic             cpu_en_r;
  logic             periph_en_r;
  logic             adc_start_r;
  logic             running;
  logic             wr_ok;
  logic             supply_low;
  logic             pin_low;
  logic             cmp_below;
  logic             cnv_low;
  logic             clk_lost;
  logic             wd_overflow;
  logic [2:0]       wd_interval;

  // Writes only land while running
  assign running = (state_r == ST_RUN);
  assign wr_ok   = running & sfr_req.wr;

  // ==========================================================================
  // Raw reset source levels
  // ==========================================================================
  // Own pin drive is not an outside reset
  assign supply_low = supply_monitor_enable_pin & ~supply_ok;
  assign pin_low    = ~rst_pin_in & pin_oe_n_r;
  assign cmp_below  = ~noninverting_above_inverting;
  assign cnv_low    = ~convert_start_input;
  // clock loss once the one-shot window runs out
  assign clk_lost   = clk_loss_en_r && (loss_cnt_r == CNT_W'(CLOCK_LOSS_CYC_P - 1));

  // Fixed source priority
  always_comb begin
    trig = CAUSE_NONE;
    if (supply_low || por_force_r) begin
      trig = CAUSE_SUPPLY;
    end else if (pin_low) begin
      trig = CAUSE_PIN;
    end else if (clk_lost) begin
      trig = CAUSE_CLOCK;
    // comparator below gated by its enable
    end else if (cmp_en_r && cmp_below) begin
      trig = CAUSE_CMP;
    // convert input low gated by its enable
    end else if (cnv_en_r && cnv_low) begin
      trig = CAUSE_CNV;
    end else if (sw_force_r) begin
      trig = CAUSE_SW;
    end else if (wd_overflow) begin
      trig = CAUSE_WD;
    end
  end

  // ==========================================================================
  // Reset sequencer
  // ==========================================================================
  // Next state; supply loss overrides all
  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_RUN: begin
        if (trig == CAUSE_SUPPLY) begin
          state_nxt = ST_SETTLE;
          cause_nxt = trig;
          cnt_nxt   = '0;
        end else if (trig != CAUSE_NONE) begin
          state_nxt = ST_HOLD;
          cause_nxt = trig;
        end
      end
      ST_HOLD: begin
        // Level sources hold while active
        if ((cause_r == CAUSE_PIN) && !pin_low) begin
          state_nxt = ST_PIN_EXIT;
          cnt_nxt   = '0;
        end else if ((cause_r == CAUSE_CMP) && !cmp_below) begin
          state_nxt = ST_CLK_WAIT;
        end else if ((cause_r == CAUSE_CNV) && !cnv_low) begin
          state_nxt = ST_CLK_WAIT;
        end else if ((cause_r != CAUSE_PIN) && (cause_r != CAUSE_CMP) &&
                     (cause_r != CAUSE_CNV)) begin
          state_nxt = ST_CLK_WAIT;
        end
      end
      ST_PIN_EXIT: begin
        // twelve cycles after the pin rises
        if (cnt_r == CNT_W'(PIN_EXIT_CYC - 1)) begin
          state_nxt = ST_CLK_WAIT;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_SETTLE: begin
        // settle timer; restarts while supply low
        if (supply_low) begin
          cnt_nxt = '0;
        end else if (cnt_r == CNT_W'(SUPPLY_CYC - 1)) begin
          state_nxt = ST_CLK_WAIT;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_CLK_WAIT: begin
        // execution starts once the clock is stable
        if (osc_stable) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_SETTLE;
        cause_nxt = CAUSE_SUPPLY;
        cnt_nxt   = '0;
      end
    endcase
    // supply loss re-enters reset from anywhere
    if (state_r != ST_RUN && state_r != ST_SETTLE && supply_low) begin
      state_nxt = ST_SETTLE;
      cause_nxt = CAUSE_SUPPLY;
      cnt_nxt   = '0;
    // pin low during a softer reset takes over
    end else if (state_r != ST_RUN && state_r != ST_SETTLE && pin_low) begin
      state_nxt = ST_HOLD;
      cause_nxt = CAUSE_PIN;
    end
  end

  // Power-on starts the settle period
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_r <= ST_SETTLE;
      cause_r <= CAUSE_SUPPLY;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // cause flags written on exit, every exit clears the rest
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      flags_r <= RESET_CAUSE_RST;
    end else if (state_r == ST_CLK_WAIT && state_nxt == ST_RUN) begin
      flags_r <= RESET_CAUSE_RST;
      case (cause_r)
        CAUSE_SUPPLY: flags_r[RC_POR] <= 1'b1;
        CAUSE_PIN:    flags_r[RC_PIN] <= 1'b1;
        CAUSE_CLOCK:  flags_r[RC_CLK] <= 1'b1;
        CAUSE_CMP:    flags_r[RC_CMP] <= 1'b1;
        CAUSE_CNV:    flags_r[RC_CNV] <= 1'b1;
        CAUSE_SW:     flags_r[RC_SW]  <= 1'b1;
        CAUSE_WD:     flags_r[RC_WD]  <= 1'b1;
        default:      flags_r[RC_POR] <= 1'b0;
      endcase
    end
  end

  // ==========================================================================
  // Reset cause register writes
  // ==========================================================================
  // Enables clear in every reset state
  always_ff @(posedge ref_clk) begin
    if (!rstn || !running) begin
      clk_loss_en_r <= 1'b0;
      cmp_en_r      <= 1'b0;
      cnv_en_r      <= 1'b0;
      sw_force_r    <= 1'b0;
      por_force_r   <= 1'b0;
    end else begin
      sw_force_r  <= wr_ok && (sfr_req.addr == ADDR_RESET_CAUSE) && sfr_req.wdata[RC_SW];
      por_force_r <= wr_ok && (sfr_req.addr == ADDR_RESET_CAUSE) && sfr_req.wdata[RC_PIN];
      if (wr_ok && sfr_req.addr == ADDR_RESET_CAUSE) begin
        // clock loss enable written through its flag bit
        clk_loss_en_r <= sfr_req.wdata[RC_CLK];
        // comparator enable written through its flag bit
        cmp_en_r      <= sfr_req.wdata[RC_CMP];
        // convert input enable written through its flag bit
        cnv_en_r      <= sfr_req.wdata[RC_CNV];
      end
    end
  end

  // Clock loss one-shot, rearmed by ticks
  always_ff @(posedge ref_clk) begin
    if (!rstn || !running || !clk_loss_en_r || sysclk_tick) begin
      loss_cnt_r <= '0;
    end else if (!clk_lost) begin
      loss_cnt_r <= loss_cnt_r + 1'b1;
    end
  end

  // ==========================================================================
  // Power modes
  // ==========================================================================
  // stop leaves only through reset; idle ends on interrupt
  always_ff @(posedge ref_clk) begin
    if (!rstn || !running) begin
      idle_r <= POWER_MODE_RST[PM_IDLE];
      stop_r <= POWER_MODE_RST[PM_STOP];
    end else begin
      if (wr_ok && sfr_req.addr == ADDR_POWER_MODE && sfr_req.wdata[PM_IDLE]) begin
        idle_r <= 1'b1;
      end else if (irq_pending) begin
        idle_r <= 1'b0;
      end
      if (wr_ok && sfr_req.addr == ADDR_POWER_MODE && sfr_req.wdata[PM_STOP]) begin
        stop_r <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Watchdog
  // ==========================================================================
  // counts every ref_clk cycle; frozen while stopped
  watchdog_timer u_watchdog (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .sys_reset (!running),
    .count_en  (!stop_r),
    .wr        (wr_ok && (sfr_req.addr == ADDR_WATCHDOG)),
    .wdata     (sfr_req.wdata),
    .interval  (wd_interval),
    .overflow  (wd_overflow)
  );

  // ==========================================================================
  // Register reads
  // ==========================================================================
  // mode bits always read zero
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rdata_r <= 8'h00;
    end else if (sfr_req.rd) begin
      case (sfr_req.addr)
        ADDR_POWER_MODE:  rdata_r <= POWER_MODE_RST;
        ADDR_RESET_CAUSE: rdata_r <= flags_r;
        ADDR_WATCHDOG:    rdata_r <= {5'h00, wd_interval};
        default:          rdata_r <= 8'h00;
      endcase
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // one reset level halts core, presets registers and stack
  // pointer; data memory has no connection to it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sys_reset_r   <= 1'b1;
      port_preset_r <= 1'b1;
      osc_def_r     <= 1'b1;
    end else begin
      sys_reset_r   <= (state_nxt != ST_RUN);
      // latches load all ones on the same edge as sys_reset
      port_preset_r <= (state_nxt != ST_RUN);
      osc_def_r     <= (state_nxt != ST_RUN);
    end
  end

  // pin driven low only for supply and power-on resets
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pin_oe_n_r <= 1'b0;
    end else begin
      pin_oe_n_r <= (state_nxt != ST_SETTLE);
    end
  end

  // clock gating follows the mode bits
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cpu_en_r    <= 1'b0;
      periph_en_r <= 1'b1;
      osc_en_r    <= 1'b1;
    end else begin
      cpu_en_r    <= (state_nxt == ST_RUN) && !idle_r && !stop_r;
      periph_en_r <= !stop_r;
      osc_en_r    <= !stop_r;
    end
  end

  // fall starts conversion unless a reset source
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cnv_prev_r  <= 1'b1;
      adc_start_r <= 1'b0;
    end else begin
      cnv_prev_r  <= convert_start_input;
      adc_start_r <= running && !cnv_en_r && cnv_prev_r && !convert_start_input;
    end
  end

  assign sfr_rdata         = rdata_r;
  assign rst_pin_out       = 1'b0;
  assign rst_pin_oe_n      = pin_oe_n_r;
  assign sys_reset         = sys_reset_r;
  assign port_preset       = port_preset_r;
  assign osc_enable        = osc_en_r;
  assign osc_default_sel   = osc_def_r;
  assign cpu_clk_en        = cpu_en_r;
  assign periph_clk_en     = periph_en_r;
  assign adc_convert_start = adc_start_r;

endmodule : reset_power_watchdog_ctrl

`default_nettype wire

// ### hw/rst_pwr_pkg.sv
// Constants, types and register map of the reset and power-mode controller
`default_nettype none

package rst_pwr_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_MHZ           = 125;
  localparam int unsigned SUPPLY_SETTLE_MS  = 100;
  localparam int unsigned SUPPLY_SETTLE_CYC = SUPPLY_SETTLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned CLOCK_LOSS_US     = 100;
  localparam int unsigned CLOCK_LOSS_CYC    = CLOCK_LOSS_US * CLK_MHZ;
  localparam int unsigned PIN_EXIT_CYC      = 12;
  localparam int unsigned CNT_W             = 24;
  localparam logic [2:0]  WD_KEY_GAP_CYC    = 3'h4;
  localparam int unsigned WD_WIDTH          = 21;
  localparam logic [4:0]  WD_EXP_BASE       = 5'h06;

  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [7:0] ADDR_POWER_MODE  = 8'h87;
  localparam logic [7:0] ADDR_RESET_CAUSE = 8'hEF;
  localparam logic [7:0] ADDR_WATCHDOG    = 8'hFF;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int unsigned PM_IDLE = 0;
  localparam int unsigned PM_STOP = 1;
  localparam int unsigned RC_PIN  = 0;
  localparam int unsigned RC_POR  = 1;
  localparam int unsigned RC_CLK  = 2;
  localparam int unsigned RC_WD   = 3;
  localparam int unsigned RC_SW   = 4;
  localparam int unsigned RC_CMP  = 5;
  localparam int unsigned RC_CNV  = 6;
  localparam int unsigned WD_IVL_MSB   = 2;
  localparam int unsigned WD_SET_GUARD = 7;

  localparam logic [7:0] POWER_MODE_RST  = 8'h00;
  localparam logic [7:0] RESET_CAUSE_RST = 8'h00;
  localparam logic [2:0] WD_INTERVAL_RST = 3'h7;

  // Watchdog control keys
  localparam logic [7:0] WD_KEY_RESTART = 8'hA5;
  localparam logic [7:0] WD_KEY_DIS1    = 8'hDE;
  localparam logic [7:0] WD_KEY_DIS2    = 8'hAD;
  localparam logic [7:0] WD_KEY_LOCK    = 8'hFF;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    CAUSE_NONE, CAUSE_SUPPLY, CAUSE_PIN, CAUSE_CLOCK,
    CAUSE_CMP, CAUSE_CNV, CAUSE_SW, CAUSE_WD
  } cause_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;

endpackage : rst_pwr_pkg

`default_nettype wire

// ### hw/watchdog_timer.sv
// Watchdog timer with restart, disable keys and lockout
`default_nettype none

module watchdog_timer
  import rst_pwr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       sys_reset,
  input  wire logic       count_en,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic [2:0]      interval,
  output logic            overflow
);

  logic [WD_WIDTH-1:0] count_r;
  logic [WD_WIDTH-1:0] limit;
  logic [2:0]          interval_r;
  logic [2:0]          key_gap_r;
  logic                enabled_r;
  logic                locked_r;
  logic                overflow_r;
  logic                clear;

  assign clear    = ~rstn | sys_reset;
  assign interval = interval_r;
  assign overflow = overflow_r;

  // interval is four to the power three plus field
  assign limit = WD_WIDTH'(1) << (WD_EXP_BASE + {1'b0, interval_r, 1'b0});

  // count and overflow; key A5 restarts and enables
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      count_r    <= '0;
      overflow_r <= 1'b0;
    end else if (wr && wdata == WD_KEY_RESTART) begin
      count_r    <= '0;
      overflow_r <= 1'b0;
    end else if (enabled_r && count_en) begin
      overflow_r <= (count_r == limit - WD_WIDTH'(1));
      count_r    <= (count_r == limit - WD_WIDTH'(1)) ? '0 : count_r + 1'b1;
    end else begin
      overflow_r <= 1'b0;
    end
  end

  // enabled after any reset; disable needs both keys close
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      enabled_r <= 1'b1;
      key_gap_r <= '0;
    end else begin
      if (wr && wdata == WD_KEY_DIS1) begin
        key_gap_r <= WD_KEY_GAP_CYC;
      end else if (key_gap_r != '0) begin
        key_gap_r <= key_gap_r - 1'b1;
      end
      if (wr && wdata == WD_KEY_RESTART) begin
        enabled_r <= 1'b1;
      end else if (wr && wdata == WD_KEY_DIS2 && key_gap_r != '0 && !locked_r) begin
        enabled_r <= 1'b0;
      end
    end
  end

  // lockout key holds until the next system reset
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      locked_r <= 1'b0;
    end else if (wr && wdata == WD_KEY_LOCK) begin
      locked_r <= 1'b1;
    end
  end

  // interval field, set with guard bit low
  always_ff @(posedge ref_clk) begin
    if (clear) begin
      interval_r <= WD_INTERVAL_RST;
    end else if (wr && !wdata[WD_SET_GUARD]) begin
      interval_r <= wdata[WD_IVL_MSB:0];
    end
  end

endmodule : watchdog_timer

`default_nettype wire

// ### testbench/rst_pwr_monitor.sv
// Port checks for the reset and power-mode controller
`default_nettype none

module rst_pwr_monitor
  import rst_pwr_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire sfr_req_s   sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic       supply_ok,
  input wire logic       supply_monitor_enable_pin,
  input wire logic       rst_pin_in,
  input wire logic       rst_pin_oe_n,
  input wire logic       osc_enable,
  input wire logic       osc_default_sel,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       sys_reset,
  input wire logic       port_preset,
  input wire logic       convert_start_input,
  input wire logic       adc_convert_start
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  logic pm_wr;
  // Writes land only while running
  assign pm_wr = sfr_req.wr && !sys_reset && sfr_req.addr == ADDR_POWER_MODE;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  a_preset_tracks: assert property (
    port_preset == sys_reset) else $error("port preset differs from reset");
  a_halt_in_reset: assert property (
    sys_reset && $past(sys_reset) |-> !cpu_clk_en && osc_default_sel)
    else $error("core not halted in reset");
  a_stop_osc_off: assert property (
    pm_wr && sfr_req.wdata[PM_STOP] |-> ##[1:3] !osc_enable && !periph_clk_en)
    else $error("stop write left oscillator on");
  a_idle_gate: assert property (
    pm_wr && sfr_req.wdata[PM_IDLE] && !sfr_req.wdata[PM_STOP]
    |-> ##[1:3] !cpu_clk_en && periph_clk_en) else $error("idle gating wrong");
  a_pm_reads_zero: assert property (
    sfr_req.rd && sfr_req.addr == ADDR_POWER_MODE |=> sfr_rdata == 8'h00)
    else $error("power mode read not zero");
  a_wd_read_top: assert property (
    sfr_req.rd && sfr_req.addr == ADDR_WATCHDOG |=> sfr_rdata[7:3] == 5'h00)
    else $error("watchdog read upper bits set");
  a_pin_enter: assert property (
    !rst_pin_in && !sys_reset |=> sys_reset) else $error("pin low did not reset");
  a_pin_hold: assert property (
    $rose(rst_pin_in) && $past(rst_pin_oe_n) && sys_reset
    |=> sys_reset[*8] ##1 sys_reset[*3]) else $error("pin reset exit too early");
  a_supply_drive: assert property (
    !supply_ok && supply_monitor_enable_pin |-> ##[1:2] !rst_pin_oe_n)
    else $error("supply fail did not drive pin");
  a_cnv_start: assert property (
    adc_convert_start |-> !$past(convert_start_input)
    && $past(convert_start_input, 2)) else $error("convert pulse without fall");
endmodule : rst_pwr_monitor

`default_nettype wire

// ### testbench/supply_pin_model.sv
// Supply monitor, external reset circuit and system clock source
`default_nettype none

module supply_pin_model (
  input  wire logic ref_clk,
  input  wire logic supply_dip,
  input  wire logic ext_low,
  input  wire logic clk_halt,
  input  wire logic rst_pin_oe_n,
  output logic      supply_ok,
  output logic      rst_pin_in,
  output logic      sysclk_tick,
  output logic      osc_stable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] settle_r;

  // Pin has a pull-up; either party may pull it low
  assign rst_pin_in  = !(ext_low || !rst_pin_oe_n);
  assign supply_ok   = !supply_dip;
  assign sysclk_tick = !clk_halt;
  assign osc_stable  = settle_r == 3'h7;

  // Oscillator settles a few cycles after a dip or halt
  always_ff @(posedge ref_clk) begin
    if (supply_dip || clk_halt) settle_r <= 3'h0;
    else if (settle_r != 3'h7) settle_r <= settle_r + 3'h1;
  end
endmodule : supply_pin_model

`default_nettype wire

// ### testbench/reset_power_watchdog_ctrl_tb.sv
// Self-checking bench for the reset and power-mode controller
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end

module reset_power_watchdog_ctrl_tb;
  import rst_pwr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SUP = 50;
  sfr_req_s   sfr_req;
  logic [7:0] sfr_rdata;
  logic ref_clk, rstn, supply_dip, ext_low, clk_halt, irq_pending, seen;
  logic supply_monitor_enable_pin;
  logic noninverting_above_inverting, convert_start_input, supply_ok, rst_pin_in;
  logic rst_pin_out, rst_pin_oe_n, sysclk_tick, osc_stable, sys_reset, port_preset;
  logic osc_enable, osc_default_sel, cpu_clk_en, periph_clk_en, adc_convert_start;
  int   miscompares = 0;
  int   check_count = 0;
  int   n;

  reset_power_watchdog_ctrl #(.SUPPLY_CYC(SUP), .CLOCK_LOSS_CYC_P(20)) uut (.*);

  supply_pin_model model (.*);

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) sfr_req <= '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) sfr_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk) sfr_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) sfr_req <= '0;
    @(posedge ref_clk) #1 `CHK(sfr_rdata, e)
  endtask : rd

  // Bounded wait for a reset level
  task automatic wait_sr(input logic v, input int lim, output int k);
    k = 0;
    while (sys_reset !== v && k < lim) begin
      @(posedge ref_clk) #1 k++;
    end
    `CHK(sys_reset, v)
  endtask : wait_sr

  // Enable a source, trip it, check pin and flag
  task automatic src_reset(input logic [7:0] en);
    wr(ADDR_RESET_CAUSE, en);
    @(posedge ref_clk) begin
      noninverting_above_inverting <= !en[RC_CMP];
      convert_start_input <= !en[RC_CNV];
      clk_halt <= en[RC_CLK];
    end
    wait_sr(1'b1, 40, n);
    `CHK(rst_pin_oe_n, 1'b1)
    @(posedge ref_clk) begin
      noninverting_above_inverting <= 1'b1;
      convert_start_input <= 1'b1;
      clk_halt <= 1'b0;
    end
    wait_sr(1'b0, 60, n);
    rd(ADDR_RESET_CAUSE, en);
  endtask : src_reset

  task automatic wd_fast();
    wr(ADDR_WATCHDOG, WD_KEY_RESTART);
    wr(ADDR_WATCHDOG, 8'h00);
  endtask : wd_fast

  task automatic wd_bite();
    wait_sr(1'b1, 80, n);
    `CHK(rst_pin_oe_n, 1'b1)
    wait_sr(1'b0, 60, n);
    rd(ADDR_RESET_CAUSE, 8'h08);
  endtask : wd_bite

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  // ==========================================================================
  // Clock, watchdog and tests
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Whole run needs under 1000 cycles
  initial begin
    repeat (6000) @(posedge ref_clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    sfr_req = '0;
    supply_monitor_enable_pin = 1'b1;
    rstn = 1'b0;
    supply_dip = 1'b1;
    ext_low = 1'b0;
    clk_halt = 1'b0;
    irq_pending = 1'b0;
    noninverting_above_inverting = 1'b1;
    convert_start_input = 1'b1;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    supply_dip <= 1'b0;
    @(posedge ref_clk) #1 `CHK({rst_pin_oe_n, port_preset, osc_default_sel}, 3'b011)
    wait_sr(1'b0, 200, n);
    rd(ADDR_RESET_CAUSE, 8'h02);
    rd(ADDR_WATCHDOG, {5'h00, WD_INTERVAL_RST});
    rd(8'h10, 8'h00);
    wr(ADDR_POWER_MODE, 8'h01);
    repeat (3) @(posedge ref_clk) #1 `CHK({cpu_clk_en, periph_clk_en}, 2'b01)
    rd(ADDR_POWER_MODE, 8'h00);
    @(posedge ref_clk) irq_pending <= 1'b1;
    @(posedge ref_clk) irq_pending <= 1'b0;
    repeat (3) @(posedge ref_clk) #1 `CHK(cpu_clk_en, 1'b1)
    wr(ADDR_POWER_MODE, 8'h02);
    repeat (3) @(posedge ref_clk) #1 `CHK({osc_enable, periph_clk_en}, 2'b00)
    @(posedge ref_clk) ext_low <= 1'b1;
    wait_sr(1'b1, 4, n);
    `CHK({rst_pin_oe_n, port_preset}, 2'b11)
    repeat (4) @(posedge ref_clk);
    ext_low <= 1'b0;
    wait_sr(1'b0, 40, n);
    `CHK(n >= PIN_EXIT_CYC, 1'b1)
    rd(ADDR_RESET_CAUSE, 8'h01);
    // Plain convert input starts conversions
    seen = 1'b0;
    @(posedge ref_clk) convert_start_input <= 1'b0;
    repeat (3) @(posedge ref_clk) #1 seen |= adc_convert_start;
    `CHK(seen, 1'b1)
    @(posedge ref_clk) convert_start_input <= 1'b1;
    // Comparator on and input routed first
    src_reset(8'h20);
    src_reset(8'h40);
    src_reset(8'h04);
    // Timely restarts, then none
    wd_fast();
    repeat (50) @(posedge ref_clk);
    wr(ADDR_WATCHDOG, WD_KEY_RESTART);
    repeat (50) @(posedge ref_clk) #1 `CHK(sys_reset, 1'b0)
    wd_bite();
    rd(ADDR_WATCHDOG, 8'h07);
    wd_fast();
    wr(ADDR_WATCHDOG, WD_KEY_DIS1);
    repeat (5) @(posedge ref_clk);
    wr(ADDR_WATCHDOG, WD_KEY_DIS2);
    wd_bite();
    wd_fast();
    wr(ADDR_WATCHDOG, WD_KEY_LOCK);
    wr(ADDR_WATCHDOG, WD_KEY_DIS1);
    wr(ADDR_WATCHDOG, WD_KEY_DIS2);
    wd_bite();
    wd_fast();
    wr(ADDR_WATCHDOG, WD_KEY_DIS1);
    wr(ADDR_WATCHDOG, WD_KEY_DIS2);
    repeat (150) @(posedge ref_clk) #1 `CHK(sys_reset, 1'b0)
    wr(ADDR_WATCHDOG, WD_KEY_RESTART);
    wd_bite();
    @(posedge ref_clk) begin
      supply_monitor_enable_pin <= 1'b0;
      supply_dip <= 1'b1;
    end
    repeat (3) @(posedge ref_clk) #1 `CHK(sys_reset, 1'b0)
    @(posedge ref_clk) supply_monitor_enable_pin <= 1'b1;
    wait_sr(1'b1, 4, n);
    `CHK({rst_pin_oe_n, rst_pin_out}, 2'b00)
    @(posedge ref_clk) supply_dip <= 1'b0;
    wait_sr(1'b0, 200, n);
    `CHK(n >= SUP, 1'b1)
    rd(ADDR_RESET_CAUSE, 8'h02);
    report_and_stop();
  end
endmodule : reset_power_watchdog_ctrl_tb

bind reset_power_watchdog_ctrl rst_pwr_monitor mon (.*);

`default_nettype wire
